// *** verilog/art_timer.sv ***
// Summary of operation
// - Reset clears counter; counts up once clocked
// - Pulse frequency is counter clock over (4096-reload)
// - Overflow reloads, transfers duty, drives pulse high
// - Counter equal to duty drives pulse low
// - Polarity bit inverts the pulse output
// - Output enable gives pin to pulse generator
// - Upper write suspends compare until lower write
// - Compare mode uses new duty value immediately
// - Counter reaching compare value sets flag, interrupt
// - Zero compare value never matches
// - Overflow copies duty into shadow; mode picks reference
// - Slow mode divides the CPU clock source by 32
// - Halt stops timer; active-halt mostly stops
// - Separate overflow and compare requests, maskable
// - Wake sources differ for wait and active-halt
// - Duty resolution is one count per period
// - Two-bit clock select, applied after overflow, or at once while the active select is CK_OFF
// - Overflow flag set on overflow, cleared by read
// - Compare flag cleared by reading its register
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module art_timer (
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  input  wire art_pkg::art_apb_req_t apb_req_i,
  output art_pkg::art_apb_rsp_t      apb_rsp_o,
  input  wire logic                  ltimer_tick_i,
  input  wire art_pkg::art_pwr_t     pwr_i,
  output logic                       pulse_output_o,
  output logic                       pulse_output_oe_o,
  output logic                       ovf_irq_o,
  output logic                       cmp_irq_o,
  output logic                       wake_wait_o,
  output logic                       wake_active_halt_o
);

  typedef struct packed {
    logic [1:0]  ck;
    logic [1:0]  ck_act;
    logic        ovf;
    logic        overflow_irq_enable;
    logic        compare_irq_enable;
    logic [11:0] cnt;
    logic [3:0]  cnt_hi_buf;
    logic [11:0] reload;
    logic        oe;
    logic        op;
    logic        cmpf;
    logic [11:0] duty;
    logic [11:0] shadow;
    logic        armed;
    logic        moved;
    logic        ovf_seen;
    logic [7:0]  rdata;
    logic        pready;
    logic        pslverr;
    logic        ovf_irq;
    logic        cmp_irq;
    logic        wake_wait;
    logic        wake_ahalt;
  } art_top_st_t;

  art_top_st_t q;
  art_top_st_t next_q;

  logic        tick;
  logic        ovf_evt;
  logic        match_evt;
  logic [11:0] cmp_ref;
  logic        acc;
  logic [5:0]  idx;
  logic [7:0]  wbyte;
  logic        aligned;

  art_tick u_tick (
    .core_clk_i    (core_clk_i),
    .nrst_i        (nrst_i),
    .sel_i         (q.ck_act),
    .ltimer_tick_i (ltimer_tick_i),
    .overflow_irq_enable_i       (q.overflow_irq_enable),
    .pwr_i         (pwr_i),
    .tick_o        (tick)
  );

  art_pwm_out u_pwm (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .ovf_evt_i   (q.ovf_seen),
    .match_evt_i (match_evt && q.oe),
    .oe_i        (q.oe),
    .op_i        (q.op),
    .pin_o       (pulse_output_o),
    .pin_oe_o    (pulse_output_oe_o)
  );

  always_comb begin
    next_q         = q;
    next_q.pready  = 1'b0;
    next_q.pslverr = 1'b0;

    // Counter passes its top count and wraps to the reload value
    ovf_evt = tick && (q.cnt == art_pkg::CNT_MAX);

    // A counter on CK_OFF would never overflow, so a fresh selection
    // is taken at once; with any other active select it switches only at overflow.
    if (q.ck_act == art_pkg::CK_OFF) begin
      next_q.ck_act = q.ck;
    end

    if (ovf_evt) begin
      next_q.cnt    = q.reload;
      next_q.shadow = q.duty;
      next_q.ck_act = q.ck;
    end else if (tick) begin
      next_q.cnt = q.cnt + art_pkg::CNT_ONE;
    end

    // Compare looks at the value the counter has just taken
    next_q.moved = tick;
    // Rise lags the reload as the fall lags the match: exact high time
    next_q.ovf_seen = ovf_evt;
    cmp_ref      = q.oe ? q.shadow : q.duty;
    match_evt    = q.moved && q.armed &&
                   (cmp_ref != art_pkg::CNT_ZERO) &&
                   (q.cnt == cmp_ref);

    acc     = apb_req_i.psel && apb_req_i.penable && !q.pready;
    idx     = apb_req_i.paddr[7:2];
    wbyte   = apb_req_i.pwdata[7:0];
    aligned = (apb_req_i.paddr[1:0] == 2'h0);

    if (acc) begin
      next_q.pready = 1'b1;
      next_q.rdata  = art_pkg::BYTE_ZERO;
      if (!aligned) begin
        next_q.pslverr = 1'b1;
      end else if (apb_req_i.pwrite) begin
        unique case (idx)
          art_pkg::IDX_TCS: begin
            next_q.ck    = wbyte[art_pkg::TCS_CK +: 2];
            next_q.overflow_irq_enable = wbyte[art_pkg::TCS_OVERFLOW_IRQ_ENABLE];
            next_q.compare_irq_enable = wbyte[art_pkg::TCS_COMPARE_IRQ_ENABLE];
          end
          art_pkg::IDX_RLD_H: begin
            next_q.reload[11:8] = wbyte[art_pkg::HI_W-1:0];
          end
          art_pkg::IDX_RLD_L: begin
            next_q.reload[7:0] = wbyte;
          end
          art_pkg::IDX_PCR: begin
            next_q.oe = wbyte[art_pkg::PCR_OE];
          end
          art_pkg::IDX_PCS: begin
            next_q.op = wbyte[art_pkg::PCS_OP];
          end
          art_pkg::IDX_DTY_H: begin
            next_q.duty[11:8] = wbyte[art_pkg::HI_W-1:0];
            next_q.armed      = 1'b0;
          end
          art_pkg::IDX_DTY_L: begin
            next_q.duty[7:0] = wbyte;
            next_q.armed     = 1'b1;
          end
          art_pkg::IDX_CNT_H, art_pkg::IDX_CNT_L: begin
            next_q.pslverr = 1'b0;
          end
          default: begin
            next_q.pslverr = 1'b1;
          end
        endcase
      end else begin
        unique case (idx)
          art_pkg::IDX_TCS: begin
            next_q.rdata = {3'h0, q.ck, q.ovf, q.overflow_irq_enable, q.compare_irq_enable};
            next_q.ovf   = 1'b0;
          end
          art_pkg::IDX_CNT_H: begin
            next_q.rdata = {4'h0, q.cnt_hi_buf};
          end
          art_pkg::IDX_CNT_L: begin
            // Freeze the upper bits so the pair reads coherently
            next_q.rdata      = q.cnt[7:0];
            next_q.cnt_hi_buf = q.cnt[11:8];
          end
          art_pkg::IDX_RLD_H: begin
            next_q.rdata = {4'h0, q.reload[11:8]};
          end
          art_pkg::IDX_RLD_L: begin
            next_q.rdata = q.reload[7:0];
          end
          art_pkg::IDX_PCR: begin
            next_q.rdata = {7'h00, q.oe};
          end
          art_pkg::IDX_PCS: begin
            next_q.rdata = {6'h00, q.op, q.cmpf};
            next_q.cmpf  = 1'b0;
          end
          art_pkg::IDX_DTY_H: begin
            next_q.rdata = {4'h0, q.duty[11:8]};
          end
          art_pkg::IDX_DTY_L: begin
            next_q.rdata = q.duty[7:0];
          end
          default: begin
            next_q.pslverr = 1'b1;
          end
        endcase
      end
    end

    // Hardware sets come last so they beat a clearing read
    if (ovf_evt) begin
      next_q.ovf = 1'b1;
    end
    if (match_evt) begin
      next_q.cmpf = 1'b1;
    end

    next_q.ovf_irq = q.ovf && q.overflow_irq_enable && !pwr_i.irq_mask;
    next_q.cmp_irq = q.cmpf && q.compare_irq_enable && !pwr_i.irq_mask;
    // Wait wakes on either request; active-halt only on timebase overflow
    next_q.wake_wait  = next_q.ovf_irq || next_q.cmp_irq;
    next_q.wake_ahalt = next_q.ovf_irq &&
                        (q.ck_act == art_pkg::CK_LT);
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign apb_rsp_o.prdata  = {24'h000000, q.rdata};
  assign apb_rsp_o.pready  = q.pready;
  assign apb_rsp_o.pslverr = q.pslverr;
  assign ovf_irq_o          = q.ovf_irq;
  assign cmp_irq_o          = q.cmp_irq;
  assign wake_wait_o        = q.wake_wait;
  assign wake_active_halt_o = q.wake_ahalt;

endmodule : art_timer

// *** pkg/art_pkg.sv ***
package art_pkg;

  localparam int          CNT_W     = 12;
  localparam int          HI_W      = 4;
  localparam logic [11:0] CNT_ZERO  = 12'h000;
  localparam logic [11:0] CNT_MAX   = 12'hFFF;
  localparam logic [11:0] CNT_ONE   = 12'h001;

  // Slow power mode divides the counter's CPU clock source by this figure
  localparam int          SLOW_DIV  = 32;
  localparam logic [4:0]  SLOW_LAST = 5'(SLOW_DIV - 1);
  localparam logic [4:0]  DIV_ONE   = 5'h01;

  // Counter clock select encodings
  localparam logic [1:0]  CK_OFF    = 2'h0;
  localparam logic [1:0]  CK_LT     = 2'h1;
  localparam logic [1:0]  CK_CPU    = 2'h2;

  // Register indices; the byte address is four times the index
  localparam logic [5:0]  IDX_TCS   = 6'h0D;
  localparam logic [5:0]  IDX_CNT_H = 6'h0E;
  localparam logic [5:0]  IDX_CNT_L = 6'h0F;
  localparam logic [5:0]  IDX_RLD_H = 6'h10;
  localparam logic [5:0]  IDX_RLD_L = 6'h11;
  localparam logic [5:0]  IDX_PCR   = 6'h12;
  localparam logic [5:0]  IDX_PCS   = 6'h13;
  localparam logic [5:0]  IDX_DTY_H = 6'h17;
  localparam logic [5:0]  IDX_DTY_L = 6'h18;

  // Field positions
  localparam int          TCS_CK    = 3;
  localparam int          TCS_OVF   = 2;
  localparam int          TCS_OVERFLOW_IRQ_ENABLE = 1;
  localparam int          TCS_COMPARE_IRQ_ENABLE = 0;
  localparam int          PCS_OP    = 1;
  localparam int          PCS_CMPF  = 0;
  localparam int          PCR_OE    = 0;

  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } art_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } art_apb_rsp_t;

  typedef struct packed {
    logic slow;
    logic halt;
    logic active_halt;
    logic irq_mask;
  } art_pwr_t;

endpackage : art_pkg

// *** verilog/art_tick.sv ***
`timescale 1ns/1ps
module art_tick (
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       ltimer_tick_i,
  input  wire logic       overflow_irq_enable_i,
  input  wire art_pkg::art_pwr_t pwr_i,
  output logic            tick_o
);

  typedef struct packed {
    logic [4:0] div;
    logic       tick;
  } art_tick_st_t;

  art_tick_st_t q;
  art_tick_st_t next_q;
  logic         run;

  always_comb begin
    next_q      = q;
    next_q.tick = 1'b0;
    // Active-halt keeps only the timebase-clocked overflow source alive
    run = !pwr_i.halt &&
          (!pwr_i.active_halt ||
           (sel_i == art_pkg::CK_LT && overflow_irq_enable_i));
    unique case (sel_i)
      art_pkg::CK_LT: begin
        next_q.tick = run && ltimer_tick_i;
      end
      art_pkg::CK_CPU: begin
        if (pwr_i.slow) begin
          next_q.div  = q.div + art_pkg::DIV_ONE;
          next_q.tick = run && (q.div == art_pkg::SLOW_LAST);
        end else begin
          next_q.div  = 5'h00;
          next_q.tick = run;
        end
      end
      default: begin
        next_q.div  = 5'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick_o = q.tick;

endmodule : art_tick

// *** verilog/art_pwm_out.sv ***
`timescale 1ns/1ps
module art_pwm_out (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic ovf_evt_i,
  input  wire logic match_evt_i,
  input  wire logic oe_i,
  input  wire logic op_i,
  output logic      pin_o,
  output logic      pin_oe_o
);

  typedef struct packed {
    logic lvl;
    logic pin;
    logic oe;
  } art_pwm_st_t;

  art_pwm_st_t q;
  art_pwm_st_t next_q;

  always_comb begin
    next_q = q;
    if (!oe_i) begin
      next_q.lvl = 1'b0;
    end else if (ovf_evt_i) begin
      next_q.lvl = 1'b1;
    end else if (match_evt_i) begin
      next_q.lvl = 1'b0;
    end
    // Polarity applies only while the pin is ours
    next_q.pin = oe_i ? (next_q.lvl ^ op_i) : 1'b0;
    next_q.oe  = oe_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pin_o    = q.pin;
  assign pin_oe_o = q.oe;

endmodule : art_pwm_out

// *** testbench/art_cpu_model.sv ***
`timescale 1ns/1ps
module art_cpu_model (
  input  wire art_pkg::art_apb_rsp_t rsp_i,
  input  wire logic                  core_clk_i,
  output art_pkg::art_apb_req_t      req_o,
  output logic                       tick_o
);
  logic [1:0] div = 2'h0;
  initial req_o = '0;
  initial tick_o = 1'b0;
  // Fast timebase keeps the timebase-clocked runs short
  always @(posedge core_clk_i) begin
    div    <= div + 2'h1;
    tick_o <= div == 2'h3;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge core_clk_i);
    req_o <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk_i);
    req_o.penable <= 1'b1;
    do @(posedge core_clk_i); while (rsp_i.pready !== 1'b1);
    q = rsp_i.prdata;
    e = rsp_i.pslverr;
    // Released lines change so that stale values are never trusted
    req_o <= '{1'b0, 1'b0, ~w, ~a, ~d};
  endtask : xfer
  task automatic w12(input logic [7:0] a, input logic [11:0] v);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, {28'h0, v[11:8]}, q, e);
    xfer(1'b1, a + 8'h04, {24'h0, v[7:0]}, q, e);
  endtask : w12
endmodule : art_cpu_model

// *** testbench/art_timer_properties.sv ***
`timescale 1ns/1ps
module art_timer_properties (
  input wire logic                  core_clk_i,
  input wire logic                  nrst_i,
  input wire art_pkg::art_apb_req_t apb_req_i,
  input wire art_pkg::art_apb_rsp_t apb_rsp_o,
  input wire logic                  ltimer_tick_i,
  input wire art_pkg::art_pwr_t     pwr_i,
  input wire logic                  pulse_output_o,
  input wire logic                  pulse_output_oe_o,
  input wire logic                  ovf_irq_o,
  input wire logic                  cmp_irq_o,
  input wire logic                  wake_wait_o,
  input wire logic                  wake_active_halt_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_take;
    apb_req_i.psel && apb_req_i.penable && !apb_rsp_o.pready;
  endsequence
  sequence s_oe_wr;
    s_take ##0 apb_req_i.pwrite && apb_req_i.paddr == 8'h48;
  endsequence
  property p_rst;
    $rose(nrst_i) |-> !pulse_output_oe_o && !ovf_irq_o && !cmp_irq_o;
  endproperty
  property p_ack;
    s_take |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready;
  endproperty
  property p_oe_on;
    s_oe_wr ##0 apb_req_i.pwdata[0] |-> ##[1:2] pulse_output_oe_o;
  endproperty
  property p_oe_off;
    s_oe_wr ##0 !apb_req_i.pwdata[0] |-> ##[1:2] !pulse_output_oe_o;
  endproperty
  property p_quiet;
    !pulse_output_oe_o && !$past(pulse_output_oe_o) |-> !pulse_output_o;
  endproperty
  property p_ovf_mask;
    ovf_irq_o |-> !$past(pwr_i.irq_mask);
  endproperty
  property p_cmp_mask;
    cmp_irq_o |-> !$past(pwr_i.irq_mask);
  endproperty
  property p_wake_ah;
    wake_active_halt_o |-> ovf_irq_o || $past(ovf_irq_o);
  endproperty
  property p_wake_w;
    wake_wait_o |-> ovf_irq_o || cmp_irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs set after reset");
  a_ack: assert property (p_ack) else $error("bad ready timing");
  a_oe_on: assert property (p_oe_on) else $error("enable lost");
  a_oe_off: assert property (p_oe_off) else $error("enable stuck");
  a_quiet: assert property (p_quiet) else $error("pin driven off");
  a_ovf_mask: assert property (p_ovf_mask) else $error("ovf masked");
  a_cmp_mask: assert property (p_cmp_mask) else $error("cmp masked");
  a_wake_ah: assert property (p_wake_ah) else $error("bad halt wake");
  a_wake_w: assert property (p_wake_w) else $error("bad wait wake");
endmodule : art_timer_properties
bind art_timer art_timer_properties u_props (.core_clk_i, .nrst_i,
  .apb_req_i, .apb_rsp_o, .ltimer_tick_i, .pwr_i, .pulse_output_o,
  .pulse_output_oe_o, .ovf_irq_o, .cmp_irq_o, .wake_wait_o,
  .wake_active_halt_o);

// *** testbench/autoreload_pwm_compare_timer_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, x, s) begin checked++; if ((s) !== (x)) begin err_count++; \
$display("mismatch %s exp %0h got %0h", n, x, s); end end
module autoreload_pwm_compare_timer_tb;
  logic                  core_clk_i;
  logic                  nrst_i;
  art_pkg::art_apb_req_t req;
  art_pkg::art_apb_rsp_t rsp;
  art_pkg::art_pwr_t     pwr;
  logic                  tick, pin, oe, ovi, cmi, ww, wah, e;
  logic [31:0]           q, lfsr;
  logic [11:0]           v;
  logic [7:0]            ra [9] = '{8'h34, 8'h38, 8'h3C, 8'h40, 8'h44,
                                    8'h48, 8'h4C, 8'h5C, 8'h60};
  int                    err_count, checked, cyc, n;
  art_cpu_model cpu (.core_clk_i, .rsp_i(rsp), .req_o(req), .tick_o(tick));
  art_timer DUT (.core_clk_i, .nrst_i, .apb_req_i(req), .apb_rsp_o(rsp),
    .ltimer_tick_i(tick), .pwr_i(pwr), .pulse_output_o(pin),
    .pulse_output_oe_o(oe), .ovf_irq_o(ovi), .cmp_irq_o(cmi),
    .wake_wait_o(ww), .wake_active_halt_o(wah));
  function automatic logic [31:0] nxt(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction : nxt
  function automatic int highs(input int rl, dt, pol, len);
    int h;
    h = (dt - rl) * len / (4096 - rl);
    return pol ? len - h : h;
  endfunction : highs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
    input logic xe);
    cpu.xfer(1'b0, a, 32'h0, q, e);
    `CHK("pslverr", xe, e)
    if (!xe) `CHK("prdata", x, q)
  endtask : rdc
  task automatic wait_cyc(input int len, input logic cnt);
    n = 0;
    repeat (len) begin
      @(negedge core_clk_i);
      if (cnt && pin === 1'b1) n++;
    end
  endtask : wait_cyc
  task automatic finish_test;
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge core_clk_i);
      cyc++;
      if (cyc == 30000) begin
        err_count++;
        finish_test();
      end
    end
  end
  initial begin
    nrst_i = 1'b0;
    pwr = '0;
    err_count = 0;
    checked = 0;
    lfsr = 32'h586E;
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    foreach (ra[i]) rdc(ra[i], 32'h0, 1'b0);
    rdc(8'h50, 32'h0, 1'b1);
    rdc(8'h35, 32'h0, 1'b1);
    repeat (4) begin
      lfsr = nxt(lfsr);
      v = 12'(lfsr % 4095);
      cpu.w12(8'h40, v);
      rdc(8'h40, {28'h0, v[11:8]}, 1'b0);
      rdc(8'h44, {24'h0, v[7:0]}, 1'b0);
    end
    cpu.w12(8'h40, 12'hFF8);
    cpu.w12(8'h5C, 12'hFFC);
    wr(8'h48, 32'h1);
    wr(8'h34, 32'h10);
    n = 0;
    while (pin !== 1'b1 && n < 5000) begin
      @(negedge core_clk_i);
      n++;
    end
    wait_cyc(32, 1'b1);
    `CHK("highs", highs(4088, 4092, 0, 32), n)
    wait (pin === 1'b1);
    wait (pin === 1'b0);
    cpu.w12(8'h5C, 12'hFFE);
    wait_cyc(16, 1'b0);
    wait_cyc(32, 1'b1);
    `CHK("highs", highs(4088, 4094, 0, 32), n)
    wr(8'h4C, 32'h2);
    wait_cyc(8, 1'b0);
    wait_cyc(32, 1'b1);
    `CHK("highs", highs(4088, 4094, 1, 32), n)
    @(posedge core_clk_i) pwr.slow <= 1'b1;
    wait_cyc(300, 1'b0);
    wait_cyc(512, 1'b1);
    `CHK("highs", highs(4088, 4094, 1, 512), n)
    @(posedge core_clk_i) pwr.slow <= 1'b0;
    rdc(8'h4C, 32'h3, 1'b0);
    rdc(8'h34, 32'h14, 1'b0);
    pwr.halt <= 1'b1;
    wait_cyc(4, 1'b0);
    cpu.xfer(1'b0, 8'h34, 32'h0, q, e);
    rdc(8'h34, 32'h10, 1'b0);
    cpu.xfer(1'b0, 8'h4C, 32'h0, q, e);
    rdc(8'h4C, 32'h2, 1'b0);
    cpu.xfer(1'b0, 8'h3C, 32'h0, q, e);
    rdc(8'h3C, q, 1'b0);
    rdc(8'h38, 32'hF, 1'b0);
    pwr.halt <= 1'b0;
    wr(8'h34, 32'h12);
    wait_cyc(40, 1'b0);
    `CHK("ovf_irq", 1'b1, ovi)
    `CHK("wake_wait", 1'b1, ww)
    `CHK("wake_ah", 1'b0, wah)
    @(posedge core_clk_i) pwr.irq_mask <= 1'b1;
    wait_cyc(3, 1'b0);
    `CHK("ovf_irq", 1'b0, ovi)
    wr(8'h34, 32'h0A);
    wait_cyc(20, 1'b0);
    @(posedge core_clk_i) pwr <= '{1'b0, 1'b0, 1'b1, 1'b0};
    rdc(8'h34, 32'h0E, 1'b0);
    wait_cyc(200, 1'b0);
    `CHK("wake_ah", 1'b1, wah)
    @(posedge core_clk_i) pwr.active_halt <= 1'b0;
    wr(8'h48, 32'h0);
    wait_cyc(3, 1'b0);
    `CHK("pin", 1'b0, pin)
    `CHK("pin_oe", 1'b0, oe)
    wr(8'h34, 32'h09);
    cpu.w12(8'h5C, 12'h000);
    cpu.xfer(1'b0, 8'h4C, 32'h0, q, e);
    wait_cyc(80, 1'b0);
    rdc(8'h4C, 32'h2, 1'b0);
    wr(8'h60, 32'hFA);
    wr(8'h5C, 32'hF);
    cpu.xfer(1'b0, 8'h4C, 32'h0, q, e);
    wait_cyc(80, 1'b0);
    rdc(8'h4C, 32'h2, 1'b0);
    wr(8'h60, 32'hFA);
    wait_cyc(80, 1'b0);
    `CHK("cmp_irq", 1'b1, cmi)
    rdc(8'h4C, 32'h3, 1'b0);
    finish_test();
  end
endmodule : autoreload_pwm_compare_timer_tb
